//--- reset_option_loader_defs.vh
// Offsets, field positions, reset values and timing counts for the reset option loader
`ifndef RESET_OPTION_LOADER_DEFS_VH
`define RESET_OPTION_LOADER_DEFS_VH

`define ADDR_WIDTH            8
`define REG_WATCHDOG_CONTROL  8'h3C
`define REG_FLASH_OPTION      8'h3D
`define REG_TEMP_SENSOR_CTL   8'h3E
`define REG_LOADER_STATUS     8'h3F

`define WDOG_RATE_LSB         0
`define WDOG_RATE_MSB         2
`define WDOG_WINDOW_BIT       7
`define OPT_WINDOW_BIT        3
`define OPT_SECURE_BIT        7
`define TEMP_VOLTAGE_ACCESS_SELECT_BIT         0

`define CFG_OPTION_ADDR       18'h3FF0E
`define CFG_SECURITY_ADDR     18'h3FF0F
`define FLASH_ADDR_WIDTH      18

`define WDOG_CONTROL_RESET    8'h00
`define FLASH_OPTION_RESET    8'hFF
`define TEMP_CTL_RESET        8'h00

`define FLASH_READ_LATENCY    2

`endif

//--- reset_option_loader.v
// Reset-time configuration loader: stalls the processor, loads option byte, routes triggers
//
// Behaviour
// - The processor stays stalled after every reset until the configuration copy is done.
// - A double-bit fault seen while loading leaves protection and security forced on.
// - A program or erase command running at reset is aborted at once by an abort pulse.
// - The RAM arrays get no clear or init signal from reset.
// - The watchdog rate and window fields of watchdog_control are loaded from the option image.
// - The option image is filled from the configuration byte at the fixed flash address.
// - The initial watchdog rate is the bitwise inverse of the three low option bits.
// - The initial watchdog window mode is the inverse of option bit 3.
// - Converter trigger 0 is PWM channel 1 and converter trigger 1 is PWM channel 3.
// - An active background debug session is the converter's freeze condition.
// - The voltage access select bit picks bandgap or temperature sensor for channel 17.
// - Every reset returns all registers to reset values and restarts the load sequence.
`timescale 1ns/1ps
`include "reset_option_loader_defs.vh"

module reset_option_loader #(
    parameter READ_LATENCY = `FLASH_READ_LATENCY
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    // Flash array read port
    output reg         flash_read,
    output reg  [17:0] flash_addr,
    input  wire [7:0]  flash_rdata,
    input  wire        flash_rvalid,
    input  wire        flash_double_fault,
    // Flash command control
    input  wire        flash_cmd_active,
    output wire        flash_cmd_abort,
    // Processor and protection
    output wire        cpu_stall,
    output reg         flash_protect_force,
    output reg         flash_secure_force,
    // Watchdog fields
    output wire [2:0]  watchdog_rate_select,
    output wire        watchdog_window_mode,
    // Converter connections
    input  wire [7:0]  pwm_channel,
    input  wire        background_debug_session,
    input  wire [9:0]  analog_in,
    input  wire        bandgap_voltage,
    input  wire        temp_sensor_voltage,
    output wire        conv_ext_trigger_0,
    output wire        conv_ext_trigger_1,
    output wire        conv_freeze,
    output wire        internal_channel_17,
    // Voltage access select
    output wire        voltage_access_select
);

////////////////////////////////////////////////////////////////////////////////
// Load sequencer

localparam ST_START   = 3'd0;
localparam ST_OPT_RD  = 3'd1;
localparam ST_OPT_WT  = 3'd2;
localparam ST_SEC_RD  = 3'd3;
localparam ST_SEC_WT  = 3'd4;
localparam ST_APPLY   = 3'd5;
localparam ST_DONE    = 3'd6;

reg [2:0] state;
reg [2:0] next_state;
reg [7:0] watchdog_control;
reg [7:0] flash_option_image;
reg [7:0] temp_sensor_control;
reg       load_fault;
reg       abort_armed;
reg [1:0] dbg_sync;
reg       next_flash_read;
reg [17:0] next_flash_addr;
reg [7:0] next_option_image;
reg [7:0] next_watchdog_control;
reg [7:0] next_temp_sensor_control;
reg       next_load_fault;
reg       next_protect_force;
reg       next_secure_force;
reg [7:0] next_rdata;
reg [7:0] loader_status;
wire      load_wait;
wire      load_answer;
wire      opt_answer;
wire      load_done;
wire      bus_write_open;

// Abort follows the command flag while reset holds and for one edge after it,
// so a command caught by reset is stopped before the loader touches the array
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        abort_armed <= 1'b1;
    end else begin
        abort_armed <= 1'b0;
    end
end

assign flash_cmd_abort = abort_armed & flash_cmd_active;

always @* begin
    next_state = state;
    case (state)
        ST_START: begin
            next_state = ST_OPT_RD;
        end
        ST_OPT_RD: begin
            next_state = ST_OPT_WT;
        end
        ST_OPT_WT: begin
            if (flash_rvalid) begin
                next_state = ST_SEC_RD;
            end
        end
        ST_SEC_RD: begin
            next_state = ST_SEC_WT;
        end
        ST_SEC_WT: begin
            if (flash_rvalid) begin
                next_state = ST_APPLY;
            end
        end
        ST_APPLY: begin
            next_state = ST_DONE;
        end
        ST_DONE: begin
            // Only a reset leaves this state; software cannot restart the load
            next_state = ST_DONE;
        end
        default: begin
            next_state = ST_START;
        end
    endcase
end

// Requests decode the coming state so the pulse starts with that state
always @* begin
    next_flash_read = 1'b0;
    next_flash_addr = flash_addr;
    case (next_state)
        ST_OPT_RD: begin
            next_flash_read = 1'b1;
            next_flash_addr = `CFG_OPTION_ADDR;
        end
        ST_SEC_RD: begin
            next_flash_read = 1'b1;
            next_flash_addr = `CFG_SECURITY_ADDR;
        end
        default: begin
            next_flash_read = 1'b0;
        end
    endcase
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        state      <= ST_START;
        flash_read <= 1'b0;
        flash_addr <= 18'h00000;
    end else begin
        state      <= next_state;
        flash_read <= next_flash_read;
        flash_addr <= next_flash_addr;
    end
end

// Answers outside the wait states are ignored
assign load_wait   = (state == ST_OPT_WT) || (state == ST_SEC_WT);
assign load_answer = load_wait && flash_rvalid;
assign opt_answer  = (state == ST_OPT_WT) && flash_rvalid;
assign load_done   = (state == ST_DONE);

// Stall lasts from reset until the watchdog fields are in place
assign cpu_stall = (state != ST_DONE);

////////////////////////////////////////////////////////////////////////////////
// Option image, watchdog fields and fault capture

// Option image: only the answer to the option read lands here
always @* begin
    next_option_image = flash_option_image;
    if (opt_answer) begin
        next_option_image = flash_rdata;
    end
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        flash_option_image <= `FLASH_OPTION_RESET;
    end else begin
        flash_option_image <= next_option_image;
    end
end

// A fault on either read stays until the next reset
always @* begin
    next_load_fault = load_fault;
    if (load_answer && flash_double_fault) begin
        next_load_fault = 1'b1;
    end
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        load_fault <= 1'b0;
    end else begin
        load_fault <= next_load_fault;
    end
end

// Uncorrectable faults leave the part locked rather than open
always @* begin
    next_protect_force = flash_protect_force;
    next_secure_force  = flash_secure_force;
    if (state == ST_APPLY) begin
        next_protect_force = load_fault;
        next_secure_force  = load_fault;
    end
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        flash_protect_force <= 1'b0;
        flash_secure_force  <= 1'b0;
    end else begin
        flash_protect_force <= next_protect_force;
        flash_secure_force  <= next_secure_force;
    end
end

// Software writes are shut out while the processor is held
assign bus_write_open = reg_write && load_done;

// Watchdog fields take the inverted option bits on the same edge that lifts the stall
always @* begin
    next_watchdog_control = watchdog_control;
    if (state == ST_APPLY) begin
        next_watchdog_control[`WDOG_RATE_MSB:`WDOG_RATE_LSB] =
            ~flash_option_image[2:0];
        next_watchdog_control[`WDOG_WINDOW_BIT] =
            ~flash_option_image[`OPT_WINDOW_BIT];
    end
    if (bus_write_open && reg_addr == `REG_WATCHDOG_CONTROL) begin
        next_watchdog_control = reg_wdata;
    end
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        watchdog_control <= `WDOG_CONTROL_RESET;
    end else begin
        watchdog_control <= next_watchdog_control;
    end
end

always @* begin
    next_temp_sensor_control = temp_sensor_control;
    if (bus_write_open && reg_addr == `REG_TEMP_SENSOR_CTL) begin
        next_temp_sensor_control = reg_wdata;
    end
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        temp_sensor_control <= `TEMP_CTL_RESET;
    end else begin
        temp_sensor_control <= next_temp_sensor_control;
    end
end

assign watchdog_rate_select = watchdog_control[`WDOG_RATE_MSB:`WDOG_RATE_LSB];
assign watchdog_window_mode = watchdog_control[`WDOG_WINDOW_BIT];

////////////////////////////////////////////////////////////////////////////////
// Register read port

// Status, low bit first: done, fault, protection forced, security forced
// The upper nibble reads as zero
always @* begin
    loader_status = {4'h0, flash_secure_force, flash_protect_force, load_fault, ~cpu_stall};
end

// Read data stand for one cycle only, then fall back to zero
always @* begin
    next_rdata = 8'h00;
    if (reg_read) begin
        case (reg_addr)
            `REG_WATCHDOG_CONTROL: next_rdata = watchdog_control;
            `REG_FLASH_OPTION:     next_rdata = flash_option_image;
            `REG_TEMP_SENSOR_CTL:  next_rdata = temp_sensor_control;
            `REG_LOADER_STATUS:    next_rdata = loader_status;
            default:               next_rdata = 8'h00;
        endcase
    end
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata <= 8'h00;
    end else begin
        reg_rdata <= next_rdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Converter connections

// The debug flag comes from another clock; two flops before anything reads it
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        dbg_sync <= 2'b00;
    end else begin
        dbg_sync <= {dbg_sync[0], background_debug_session};
    end
end

// Fixed wiring, not selectable by software; the converter does its own edge detection
localparam TRIG0_PWM_CHANNEL = 1;
localparam TRIG1_PWM_CHANNEL = 3;

assign conv_ext_trigger_0 = pwm_channel[TRIG0_PWM_CHANNEL];
assign conv_ext_trigger_1 = pwm_channel[TRIG1_PWM_CHANNEL];
assign conv_freeze = dbg_sync[1];
assign voltage_access_select = temp_sensor_control[`TEMP_VOLTAGE_ACCESS_SELECT_BIT];
// Analog levels pass straight through; the select only steers the mux
assign internal_channel_17 = voltage_access_select ? temp_sensor_voltage
                                                   : bandgap_voltage;

// RAM has no init port here by design; contents survive reset untouched
// Software must not rely on any RAM value after reset, nor on a word whose
// write was cut by the abort above

endmodule

//--- reset_option_loader_props.sv
// Concurrent checks on the reset option loader ports
`timescale 1ns/1ps
`include "reset_option_loader_defs.vh"
module reset_option_loader_props (
    // Clock, reset and flash side
    input logic        clock, rst_n, flash_read, flash_rvalid, flash_double_fault,
    input logic        flash_cmd_active, flash_cmd_abort, cpu_stall, reg_read,
    input logic [17:0] flash_addr,
    input logic [7:0]  flash_rdata, reg_rdata, pwm_channel,
    // Watchdog, protection and converter side
    input logic        flash_protect_force, flash_secure_force, watchdog_window_mode,
    input logic [2:0]  watchdog_rate_select,
    input logic        conv_ext_trigger_0, conv_ext_trigger_1, internal_channel_17,
    input logic        voltage_access_select, bandgap_voltage, temp_sensor_voltage,
    input logic        background_debug_session, conv_freeze
);
    logic [7:0] opt_seen;
    logic       fault_seen;
    // Own copy of what the flash returned, so expectations never come from the design
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            opt_seen   <= 8'hFF;
            fault_seen <= 1'b0;
        end else if (flash_rvalid && cpu_stall) begin
            if (flash_addr == `CFG_OPTION_ADDR) opt_seen <= flash_rdata;
            fault_seen <= fault_seen | flash_double_fault;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence last_answer;
        flash_rvalid && cpu_stall && flash_addr == `CFG_SECURITY_ADDR;
    endsequence
    sequence stall_release;
        cpu_stall ##1 !cpu_stall;
    endsequence
    a_trig_route: assert property (
        conv_ext_trigger_0 == pwm_channel[1] && conv_ext_trigger_1 == pwm_channel[3])
        else $error("trigger routing wrong");
    a_chan_select: assert property (
        internal_channel_17 == (voltage_access_select ? temp_sensor_voltage : bandgap_voltage))
        else $error("channel 17 source wrong");
    a_abort_release: assert property ($rose(rst_n) && flash_cmd_active |-> flash_cmd_abort)
        else $error("flash command not aborted");
    a_first_fetch: assert property ($rose(rst_n) |=>
        flash_read && flash_addr == `CFG_OPTION_ADDR && cpu_stall)
        else $error("option fetch missing");
    a_stall_end: assert property (last_answer |-> ##1 stall_release)
        else $error("stall release mistimed");
    a_rate_inverse: assert property ($fell(cpu_stall) |->
        watchdog_rate_select == ~opt_seen[2:0]) else $error("watchdog rate wrong");
    a_window_inverse: assert property ($fell(cpu_stall) |->
        watchdog_window_mode == !opt_seen[3]) else $error("window mode wrong");
    a_fault_force: assert property ($fell(cpu_stall) |->
        flash_protect_force == fault_seen && flash_secure_force == fault_seen)
        else $error("protection force wrong");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_freeze_sync: assert property ($past(rst_n) && $past(rst_n, 2) |->
        conv_freeze == $past(background_debug_session, 2)) else $error("freeze copy wrong");
endmodule
bind reset_option_loader reset_option_loader_props props (.*);

//--- flash_model.sv
// Behavioural flash array answering configuration reads
`timescale 1ns/1ps
`include "reset_option_loader_defs.vh"
module flash_model (
    // Design side
    input  logic        clock, rst_n, flash_read,
    input  logic [17:0] flash_addr,
    output logic [7:0]  flash_rdata,
    output logic        flash_rvalid, flash_double_fault,
    // Bench control
    input  logic [7:0]  option_byte,
    input  logic        fault_en,
    input  logic [1:0]  wait_cycles
);
    logic [1:0] count;
    logic       busy;
    wire        ready = busy && count == 2'h0;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy               <= 1'b0;
            flash_rvalid       <= 1'b0;
            flash_double_fault <= 1'b0;
            flash_rdata        <= 8'h00;
        end else begin
            flash_rvalid       <= ready;
            flash_double_fault <= ready && fault_en;
            // Released data toggles so a late sample cannot pass by luck
            flash_rdata        <= !ready ? ~flash_rdata :
                                  (flash_addr == `CFG_OPTION_ADDR ? option_byte : 8'h00);
            if (flash_read) begin
                busy  <= 1'b1;
                count <= wait_cycles;
            end else if (ready) busy <= 1'b0;
            else count <= count - 2'h1;
        end
    end
endmodule

//--- testbench.sv
// Self-checking bench for the reset option loader
`timescale 1ns/1ps
`include "reset_option_loader_defs.vh"
module testbench;
    logic        clock, rst_n, reg_write, reg_read, flash_read, flash_rvalid, fault_en;
    logic        flash_double_fault, flash_cmd_active, flash_cmd_abort, cpu_stall;
    logic        flash_protect_force, flash_secure_force, watchdog_window_mode, conv_freeze;
    logic        background_debug_session, bandgap_voltage, temp_sensor_voltage;
    logic        conv_ext_trigger_0, conv_ext_trigger_1, internal_channel_17, voltage_access_select;
    logic [1:0]  wait_cycles;
    logic [2:0]  watchdog_rate_select;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, flash_rdata, pwm_channel, option_byte;
    logic [9:0]  analog_in;
    logic [17:0] flash_addr;
    int          miscompares = 0;
    int          tests_run = 0;
    reset_option_loader dut (.*);
    flash_model flash (.*);
    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Every call is a fresh reset with a flash command caught in flight
    task automatic boot(input logic [7:0] opt, input logic [1:0] w);
        option_byte      <= opt;
        fault_en         <= w[0];
        wait_cycles      <= w;
        rst_n            <= 1'b0;
        flash_cmd_active <= 1'b1;
        repeat (12) @(posedge clock);
        chk({7'h0, flash_cmd_abort}, 8'h01);
        chk({7'h0, cpu_stall}, 8'h01);
        rst_n            <= 1'b1;
        @(posedge clock);
        flash_cmd_active <= 1'b0;
        repeat (40) if (cpu_stall !== 1'b0) @(posedge clock);
        @(posedge clock);
        rd(`REG_WATCHDOG_CONTROL, {~opt[3], 4'h0, ~opt[2:0]});
        rd(`REG_FLASH_OPTION, opt);
        wr(`REG_FLASH_OPTION, ~opt);
        rd(`REG_FLASH_OPTION, opt);
        rd(`REG_LOADER_STATUS, {4'h0, w[0], w[0], w[0], 1'b1});
        chk({6'h0, flash_protect_force, flash_secure_force}, {6'h0, w[0], w[0]});
        $display("test boot %h done", opt);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        {reg_write, reg_read, reg_addr, reg_wdata, pwm_channel, analog_in} = '0;
        {background_debug_session, bandgap_voltage, temp_sensor_voltage, rst_n} = '0;
        {option_byte, fault_en, wait_cycles, flash_cmd_active} = '0;
        for (int i = 0; i < 16; i++) boot({i[3:0], i[3:0]}, i[1:0]);
        rd(8'h10, 8'h00);
        wr(`REG_WATCHDOG_CONTROL, 8'h86);
        rd(`REG_WATCHDOG_CONTROL, 8'h86);
        chk({4'h0, watchdog_window_mode, watchdog_rate_select}, 8'h0E);
        for (int i = 0; i < 16; i++) begin
            pwm_channel <= {4'h0, i[3:0]};
            @(posedge clock);
            #1 chk({6'h0, conv_ext_trigger_1, conv_ext_trigger_0}, {6'h0, i[3], i[1]});
        end
        for (int i = 0; i < 4; i++) begin
            wr(`REG_TEMP_SENSOR_CTL, {7'h0, i[0]});
            bandgap_voltage     <= i[1];
            temp_sensor_voltage <= ~i[1];
            @(posedge clock);
            #1 chk({6'h0, voltage_access_select, internal_channel_17}, {6'h0, i[0], i[0] ^ i[1]});
        end
        background_debug_session <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk({7'h0, conv_freeze}, 8'h01);
        $display("test routing done");
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        summarize();
    end
endmodule
